// *** hdl/cpr_pkg.sv ***
// Package for the clock path, reset and multiplier control block.
// Assumes a single 40 MHz system clock and an AXI4-Lite register master.
package cpr_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CPR_CALIB_ADDR = 8'h00;  // Calibrate trigger register
  localparam logic [7:0] CPR_RESET_ADDR = 8'h04;
  localparam logic [7:0] CPR_SMCLK_ADDR = 8'h08;
  localparam logic [7:0] CPR_DIVRST_ADDR = 8'h0c;
  localparam logic [7:0] CPR_MAIN_ADDR = 8'h10;
  localparam logic [7:0] CPR_CHAN_ADDR = 8'h14;
  localparam logic [7:0] CPR_STATUS_ADDR = 8'h18;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CPR_NCH = 4;
  localparam int CPR_CH_BITS = 5;            // Per channel: path, buffer, power[2:0]
  localparam int CPR_MODE_LSB = 0;
  localparam int CPR_CODE_LSB = 3;
  localparam int CPR_SMEN_BIT = 5;
  localparam int CPR_PRE_LSB = 6;
  localparam int CPR_SDIV_LSB = 0;
  localparam logic [1:0] CPR_MODE_BUF = 2'h0;
  localparam logic [1:0] CPR_MODE_DIV = 2'h1;
  localparam logic [1:0] CPR_MODE_MULT = 2'h2;
  localparam logic [2:0] CPR_DIV_RESERVED = 3'h0;
  localparam logic [3:0] CPR_PRE_RST = 4'h2;
  localparam logic [2:0] CPR_SDIV_RST = 3'h0;
  localparam logic [2:0] CPR_MULT_RST = 3'h2;
  localparam logic [2:0] CPR_PWR_RST = 3'h7;
  localparam logic [1:0] CPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPR_RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CPR_CLK_MHZ = 40;
  localparam int CPR_CAL_US = 5000;          // First calibration runs CPR_CAL_CYC state machine clock ticks, about 10 ms with the reset divider settings
  localparam int CPR_CAL_CYC = CPR_CAL_US * CPR_CLK_MHZ;
  localparam int CPR_WDOG_CYC = 2 * CPR_CAL_CYC;
  localparam int CPR_SRST_CYC = 4;           // Soft reset pulse in cycles; a bus write arriving meanwhile waits until it ends
  typedef enum logic [1:0] {CPR_CAL_IDLE, CPR_CAL_RUN, CPR_CAL_LOCKED} cpr_cal_state_t;
  typedef struct packed {
    logic path_en;
    logic buf_en;
    logic [2:0] power;
  } cpr_chan_t;
  typedef struct packed {
    logic path_on;
    logic buf_on;
    logic [2:0] level;
  } cpr_chan_out_t;
endpackage

// *** hdl/cpr_ctrl.sv ***
// Control logic for the main clock paths, resets and multiplier calibration.
// Assumes one clock domain; the input clock is modelled by the system clock for the
// state machine clock divider, and the multiplier core reports completion on cal_done.
`timescale 1ns/1ps
`default_nettype none
module cpr_ctrl
  import cpr_pkg::*;
#(
  parameter int WDOG_CYC = CPR_WDOG_CYC,
  parameter int CAL_CYC = CPR_CAL_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cal_done,
  output cpr_chan_out_t [CPR_NCH-1:0] chan_out,
  output logic [1:0] main_clock_mode_select,
  output logic [2:0] main_divide_ratio_m1,
  output logic [2:0] main_multiply_code,
  output logic divider_reset,
  output logic state_machine_clock,
  output logic cal_running,
  output logic readback_output_pin
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic reset_bit_reg, divrst_reg, smen_reg;
  logic [1:0] mode_reg;
  logic [2:0] code_reg, sdiv_reg;
  logic [3:0] pre_reg;
  cpr_chan_t [CPR_NCH-1:0] chan_reg;
  logic [2:0] srst_cnt_reg;
  logic [31:0] wdog_reg, calcnt_reg;
  logic [11:0] smdiv_reg;
  logic smclk_reg, first_cal_reg, lock_reg;
  logic [1:0] last_mode_reg;
  cpr_cal_state_t cal_state_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire soft_rst = srst_cnt_reg != 3'h0;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg && !soft_rst;
  wire wsel_calib = awaddr_reg == CPR_CALIB_ADDR;
  wire wsel_reset = awaddr_reg == CPR_RESET_ADDR;
  wire wsel_smclk = awaddr_reg == CPR_SMCLK_ADDR;
  wire wsel_divrst = awaddr_reg == CPR_DIVRST_ADDR;
  wire wsel_main = awaddr_reg == CPR_MAIN_ADDR;
  wire wsel_chan = awaddr_reg == CPR_CHAN_ADDR;
  wire wsel_ok = wsel_calib | wsel_reset | wsel_smclk | wsel_divrst | wsel_main | wsel_chan;
  // Every write is a full word; byte strobes carry no meaning for these registers
  wire wr_all = do_write;
  wire start_rst = wr_all && wsel_reset && wdata_reg[0];
  wire cal_req = wr_all && wsel_calib;
  wire [2:0] div_code_ok = (wdata_reg[CPR_CODE_LSB +: 3] == CPR_DIV_RESERVED) ? 3'h1 :
                           wdata_reg[CPR_CODE_LSB +: 3];
  wire rd_go = s_axi_arvalid && !rvalid_reg;
  wire [31:0] chan_word;
  genvar gi;
  generate
    for (gi = 0; gi < CPR_NCH; gi++) begin : g_ch
      assign chan_word[gi*8 +: 8] = {3'h0, chan_reg[gi]};
      assign chan_out[gi].path_on = chan_reg[gi].path_en;
      assign chan_out[gi].buf_on = chan_reg[gi].path_en && chan_reg[gi].buf_en;
      assign chan_out[gi].level = chan_out[gi].buf_on ? chan_reg[gi].power : 3'h0;
    end
  endgenerate
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      CPR_CALIB_ADDR: rd_word = 32'h0;
      CPR_RESET_ADDR: rd_word = {31'h0, reset_bit_reg};
      CPR_SMCLK_ADDR: rd_word = {22'h0, pre_reg, smen_reg, 2'h0, sdiv_reg};
      CPR_DIVRST_ADDR: rd_word = {31'h0, divrst_reg};
      CPR_MAIN_ADDR: rd_word = {26'h0, code_reg, 1'b0, mode_reg};
      CPR_CHAN_ADDR: rd_word = chan_word;
      CPR_STATUS_ADDR: rd_word = {29'h0, cal_state_reg == CPR_CAL_RUN, smen_reg, lock_reg};
      default: begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CPR_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= CPR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wsel_ok ? CPR_RESP_OKAY : CPR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? CPR_RESP_OKAY : CPR_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers and soft reset
  // ----------------------------------------
  // Soft reset holds off writes for a few cycles, so it always lands before the next one.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      srst_cnt_reg <= 3'h0;
      reset_bit_reg <= 1'b0;
    end else begin
      if (start_rst) begin
        srst_cnt_reg <= 3'(CPR_SRST_CYC);
      end else if (soft_rst) begin
        srst_cnt_reg <= srst_cnt_reg - 3'h1;
      end
      if (wr_all && wsel_ok) begin
        reset_bit_reg <= wsel_reset ? wdata_reg[0] : 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= CPR_MODE_BUF;
      code_reg <= CPR_MULT_RST;
      smen_reg <= 1'b1;
      pre_reg <= CPR_PRE_RST;
      sdiv_reg <= CPR_SDIV_RST;
      divrst_reg <= 1'b0;
      for (int i = 0; i < CPR_NCH; i++) begin
        chan_reg[i] <= '{1'b1, 1'b1, CPR_PWR_RST};
      end
    end else if (soft_rst) begin
      mode_reg <= CPR_MODE_BUF;
      code_reg <= CPR_MULT_RST;
      smen_reg <= 1'b1;
      pre_reg <= CPR_PRE_RST;
      sdiv_reg <= CPR_SDIV_RST;
      divrst_reg <= 1'b0;
      for (int i = 0; i < CPR_NCH; i++) begin
        chan_reg[i] <= '{1'b1, 1'b1, CPR_PWR_RST};
      end
    end else if (wr_all) begin
      if (wsel_main) begin
        mode_reg <= wdata_reg[CPR_MODE_LSB +: 2];
        code_reg <= (wdata_reg[CPR_MODE_LSB +: 2] == CPR_MODE_DIV) ? div_code_ok :
                    wdata_reg[CPR_CODE_LSB +: 3];
      end
      if (wsel_smclk) begin
        smen_reg <= wdata_reg[CPR_SMEN_BIT];
        pre_reg <= wdata_reg[CPR_PRE_LSB +: 4];
        sdiv_reg <= wdata_reg[CPR_SDIV_LSB +: 3];
      end
      if (wsel_divrst) begin
        divrst_reg <= wdata_reg[0];
      end
      if (wsel_chan) begin
        for (int i = 0; i < CPR_NCH; i++) begin
          chan_reg[i] <= wdata_reg[i*8 +: CPR_CH_BITS];
        end
      end
    end
  end

  assign main_clock_mode_select = mode_reg;
  assign main_divide_ratio_m1 = (mode_reg == CPR_MODE_DIV) ? code_reg : 3'h0;
  assign main_multiply_code = (mode_reg == CPR_MODE_MULT) ? code_reg : 3'h0;
  assign divider_reset = divrst_reg || soft_rst;

  // ----------------------------------------
  // State machine clock divider
  // ----------------------------------------
  // Half period is prediv times 2**div / 2 input cycles; prediv of 1 would be odd, so floor at one.
  wire [11:0] sm_half = 12'(({8'h0, pre_reg} << sdiv_reg) >> 1);
  wire [11:0] sm_limit = (sm_half == 12'h0) ? 12'h0 : sm_half - 12'h1;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      smdiv_reg <= 12'h0;
      smclk_reg <= 1'b0;
    end else if (!smen_reg || soft_rst) begin
      smdiv_reg <= 12'h0;
      smclk_reg <= 1'b0;
    end else if (smdiv_reg >= sm_limit) begin
      smdiv_reg <= 12'h0;
      smclk_reg <= !smclk_reg;
    end else begin
      smdiv_reg <= smdiv_reg + 12'h1;
    end
  end
  assign state_machine_clock = smclk_reg;
  wire sm_tick = smen_reg && !soft_rst && smdiv_reg >= sm_limit && !smclk_reg;

  // ----------------------------------------
  // Calibration and watchdog
  // ----------------------------------------
  wire cal_finish = cal_done || (calcnt_reg == 32'h0 && first_cal_reg);
  wire wdog_out = wdog_reg == 32'h0;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_state_reg <= CPR_CAL_IDLE;
      wdog_reg <= 32'h0;
      calcnt_reg <= 32'h0;
      first_cal_reg <= 1'b1;
      lock_reg <= 1'b0;
      last_mode_reg <= CPR_MODE_BUF;
    end else if (soft_rst) begin
      cal_state_reg <= CPR_CAL_IDLE;
      first_cal_reg <= 1'b1;
      lock_reg <= 1'b0;
      last_mode_reg <= CPR_MODE_BUF;
    end else begin
      unique case (cal_state_reg)
        CPR_CAL_IDLE, CPR_CAL_LOCKED: begin
          if (cal_req && mode_reg == CPR_MODE_MULT) begin
            cal_state_reg <= CPR_CAL_RUN;
            lock_reg <= 1'b0;
            wdog_reg <= 32'(WDOG_CYC);
            calcnt_reg <= first_cal_reg ? 32'(CAL_CYC) : 32'h0;
          end
        end
        CPR_CAL_RUN: begin
          if (sm_tick) begin
            if (cal_finish) begin
              cal_state_reg <= CPR_CAL_LOCKED;
              lock_reg <= 1'b1;
              first_cal_reg <= 1'b0;
            end else if (wdog_out) begin
              wdog_reg <= 32'(WDOG_CYC);
              calcnt_reg <= first_cal_reg ? 32'(CAL_CYC) : 32'h0;
            end else begin
              wdog_reg <= wdog_reg - 32'h1;
              if (calcnt_reg != 32'h0) begin
                calcnt_reg <= calcnt_reg - 32'h1;
              end
            end
          end
        end
        default: cal_state_reg <= CPR_CAL_IDLE;
      endcase
      // A mode change in the cycle a calibration ends still forces the next one long
      if (mode_reg != last_mode_reg) begin
        first_cal_reg <= 1'b1;
        last_mode_reg <= mode_reg;
      end
      if (mode_reg != CPR_MODE_MULT) begin
        lock_reg <= 1'b0;
      end
    end
  end
  assign cal_running = cal_state_reg == CPR_CAL_RUN;
  assign readback_output_pin = lock_reg && smen_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_path_off_buf: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !chan_reg[0].path_en |-> !chan_out[0].buf_on && !chan_out[0].path_on)
    else $error("buffer on with path off");
  chk_buf_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    chan_reg[1].path_en && chan_reg[1].buf_en |-> chan_out[1].level == chan_reg[1].power)
    else $error("buffer level mismatch");
  chk_soft_defaults: assert property (@(posedge sys_clk) disable iff (!reset_n)
    start_rst |=> ##1 mode_reg == CPR_MODE_BUF && smen_reg)
    else $error("soft reset did not restore defaults");
  chk_write_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    soft_rst |-> !do_write)
    else $error("write taken during soft reset");
  chk_reset_bit_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_all && wsel_ok && !wsel_reset |=> !reset_bit_reg)
    else $error("reset bit not cleared");
  chk_cal_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cal_req && mode_reg == CPR_MODE_MULT && !soft_rst |=> cal_running && !lock_reg)
    else $error("calibration did not start");
  chk_div_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_reg == CPR_MODE_DIV |-> main_divide_ratio_m1 != CPR_DIV_RESERVED)
    else $error("reserved divide code in use");
  chk_lock_pin: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cal_running |-> !readback_output_pin)
    else $error("lock pin high during calibration");
  chk_wdog_restart: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cal_running && sm_tick && !cal_finish && wdog_out && !soft_rst |=> cal_running && wdog_reg == 32'(WDOG_CYC))
    else $error("watchdog did not restart calibration");
endmodule
`default_nettype wire

// *** tb/cpr_host_model.sv ***
// Host side model: an AXI4-Lite master offering one write task and one read task.
// Assumes the bench calls the tasks only after reset has been released.
`timescale 1ns/1ps
`default_nettype none
module cpr_host_model (
  input wire logic sys_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // -----------------------------
  // Bus tasks
  // -----------------------------
  // Each handshake is judged at the rising edge where the slave takes it, and released right after it.
  // Released payload is inverted so a stale value can never pass as fresh.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b_t;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    r = 2'h0;
    while (!b_t) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) begin
        b_t = 1'b1;
        r = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic r_t;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    d = 32'h0;
    r = 2'h0;
    while (!r_t) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        r_t = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/test_cpr_ctrl.sv ***
// Self-checking bench for the clock path, reset and multiplier control block.
// Assumes the host model drives the register bus and the bench stands in for the multiplier core.
`timescale 1ns/1ps
`default_nettype none
module test_cpr_ctrl;
  import cpr_pkg::*;
  localparam logic [1:0] OK = CPR_RESP_OKAY;
  localparam logic [1:0] ER = CPR_RESP_SLVERR;
  logic sys_clk, reset_n, cal_done;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  cpr_chan_out_t [CPR_NCH-1:0] chan_out;
  logic [1:0] main_clock_mode_select;
  logic [2:0] main_divide_ratio_m1, main_multiply_code;
  logic divider_reset, state_machine_clock, cal_running, readback_output_pin;
  int error_cnt = 0;
  int checks_done = 0;
  cpr_host_model i_cpr_host_model (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Short calibration and watchdog counts keep the run brief
  cpr_ctrl #(.WDOG_CYC(40), .CAL_CYC(20)) i_cpr_ctrl (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cal_done, .chan_out, .main_clock_mode_select, .main_divide_ratio_m1, .main_multiply_code,
    .divider_reset, .state_machine_clock, .cal_running, .readback_output_pin);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // -----------------------------
  // Helpers
  // -----------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_cpr_host_model.wr(a, d, r);
    chk("bresp", 32'(er), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_cpr_host_model.rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask
  // Counts rising edges of the divided clock over 256 cycles, starting on a rising edge
  task automatic sm_rises(input logic [31:0] smv, input int exp);
    logic p;
    int n, cnt;
    wr(CPR_SMCLK_ADDR, smv, OK);
    p = 1'b1;
    n = 0;
    cnt = 0;
    while (!(state_machine_clock && !p) && n < 300) begin
      p = state_machine_clock;
      @(negedge sys_clk);
      n++;
    end
    repeat (256) begin
      p = state_machine_clock;
      @(negedge sys_clk);
      if (state_machine_clock && !p) cnt++;
    end
    chk("sm_rises", 32'(exp), 32'(cnt));
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end
  // -----------------------------
  // Tests
  // -----------------------------
  initial begin
    int n;
    logic [31:0] v;
    logic [1:0] bp;
    reset_n = 1'b0;
    cal_done = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4000) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("mode", 32'h0, 32'(main_clock_mode_select));
    chk("div", 32'h0, 32'(main_divide_ratio_m1));
    chk("mult", 32'h0, 32'(main_multiply_code));
    chk("chan_out", 32'hfffff, 32'(chan_out));
    rd(CPR_SMCLK_ADDR, 32'ha0, OK);
    rd(CPR_MAIN_ADDR, 32'h10, OK);
    rd(CPR_CHAN_ADDR, 32'h1f1f1f1f, OK);
    rd(CPR_RESET_ADDR, 32'h0, OK);
    rd(CPR_STATUS_ADDR, 32'h2, OK);
    rd(8'h1c, 32'h0, ER);
    wr(CPR_STATUS_ADDR, 32'h5, ER);
    wr(8'h1c, 32'h1, ER);
    tend("defaults");
    // Per channel {buf, path}: ch0 10, ch1 01, ch2 11, ch3 00; power steps through 0..7
    // Channel byte layout: path at bit 4, buffer at bit 3, power in bits 2:0
    for (int k = 0; k < 8; k++) begin
      v = 32'h0;
      for (int i = 0; i < CPR_NCH; i++) begin
        bp = 2'(8'h36 >> (2 * i));
        v[8*i +: 5] = {bp[0], bp[1], 3'((k + i) % 8)};
      end
      wr(CPR_CHAN_ADDR, v, OK);
      @(negedge sys_clk);
      for (int i = 0; i < CPR_NCH; i++) begin
        bp = 2'(8'h36 >> (2 * i));
        chk("path_on", 32'(bp[0]), 32'(chan_out[i].path_on));
        chk("buf_on", 32'(bp[0] & bp[1]), 32'(chan_out[i].buf_on));
        if (bp == 2'b11) chk("level", 32'((k + i) % 8), 32'(chan_out[i].level));
      end
    end
    tend("channels");
    for (int c = 0; c < 8; c++) begin
      wr(CPR_MAIN_ADDR, (32'(c) << 3) | 32'(CPR_MODE_DIV), OK);
      @(negedge sys_clk);
      chk("mode", 32'(CPR_MODE_DIV), 32'(main_clock_mode_select));
      chk("div", (c == 0) ? 32'h1 : 32'(c), 32'(main_divide_ratio_m1));
      chk("mult", 32'h0, 32'(main_multiply_code));
    end
    rd(CPR_MAIN_ADDR, 32'h39, OK);
    for (int c = 2; c < 5; c++) begin
      wr(CPR_MAIN_ADDR, (32'(c) << 3) | 32'(CPR_MODE_MULT), OK);
      @(negedge sys_clk);
      chk("mode", 32'(CPR_MODE_MULT), 32'(main_clock_mode_select));
      chk("mult", 32'(c), 32'(main_multiply_code));
      chk("div", 32'h0, 32'(main_divide_ratio_m1));
    end
    wr(CPR_MAIN_ADDR, 32'h18, OK);
    @(negedge sys_clk);
    chk("mode", 32'h0, 32'(main_clock_mode_select));
    chk("mult", 32'h0, 32'(main_multiply_code));
    wr(CPR_DIVRST_ADDR, 32'h1, OK);
    @(negedge sys_clk);
    chk("divider_reset", 32'h1, 32'(divider_reset));
    wr(CPR_DIVRST_ADDR, 32'h0, OK);
    @(negedge sys_clk);
    chk("divider_reset", 32'h0, 32'(divider_reset));
    tend("modes");
    sm_rises(32'h222, 8);
    sm_rises(32'h121, 32);
    sm_rises(32'h0a0, 128);
    tend("state machine clock");
    wr(CPR_MAIN_ADDR, 32'h12, OK);
    wr(CPR_CALIB_ADDR, 32'h0, OK);
    @(negedge sys_clk);
    chk("cal_running", 32'h1, 32'(cal_running));
    n = 0;
    while (cal_running === 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk("cal_len_ok", 32'h1, 32'(n >= 30 && n <= 60));
    rd(CPR_STATUS_ADDR, 32'h3, OK);
    chk("readback_pin", 32'h1, 32'(readback_output_pin));
    // Core never reports done, so the watchdog must keep restarting the calibration
    wr(CPR_CALIB_ADDR, 32'h0, OK);
    repeat (200) @(negedge sys_clk);
    chk("cal_running", 32'h1, 32'(cal_running));
    @(posedge sys_clk);
    cal_done <= 1'b1;
    n = 0;
    while (cal_running === 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("cal_running", 32'h0, 32'(cal_running));
    @(posedge sys_clk);
    cal_done <= 1'b0;
    rd(CPR_STATUS_ADDR, 32'h3, OK);
    wr(CPR_SMCLK_ADDR, 32'h080, OK);
    @(negedge sys_clk);
    chk("readback_pin", 32'h0, 32'(readback_output_pin));
    sm_rises(32'h080, 0);
    tend("calibration");
    wr(CPR_MAIN_ADDR, 32'h29, OK);
    wr(CPR_RESET_ADDR, 32'h1, OK);
    wr(CPR_CHAN_ADDR, 32'h0, OK);
    rd(CPR_MAIN_ADDR, 32'h10, OK);
    rd(CPR_SMCLK_ADDR, 32'ha0, OK);
    rd(CPR_CHAN_ADDR, 32'h0, OK);
    rd(CPR_RESET_ADDR, 32'h0, OK);
    wr(CPR_RESET_ADDR, 32'h1, OK);
    rd(CPR_RESET_ADDR, 32'h1, OK);
    wr(CPR_RESET_ADDR, 32'h0, OK);
    rd(CPR_RESET_ADDR, 32'h0, OK);
    tend("soft reset");
    finish_test();
  end
endmodule
`default_nettype wire
